// File: far_node_model.sv
// far-end inverse-mux node: answers a link start by hunting sync on each portion
// assumes link_start is a one-cycle pulse on ref_clk from the device
`timescale 1ns/100ps
`default_nettype none
module far_node_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_start,
  input wire logic [3:0] portion_en,
  output logic [3:0] far_end_sync,
  output logic [3:0] local_sync
);
  logic [1:0] hunt_reg;
  logic hunting_reg;
  // count three consecutive sequence numbers, then report the portions in sync
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hunt_reg <= 2'h0;
      hunting_reg <= 1'b0;
      far_end_sync <= 4'h0;
    end else if (link_start) begin
      hunt_reg <= 2'h0;
      hunting_reg <= 1'b1;
      far_end_sync <= 4'h0;
    end else if (hunting_reg) begin
      hunt_reg <= hunt_reg + 2'h1;
      if (hunt_reg == 2'h2) begin
        hunting_reg <= 1'b0;
        far_end_sync <= portion_en;
      end
    end
  end
  // local receiver gains sync one cycle after the far end
  always_ff @(posedge ref_clk) begin
    local_sync <= srst ? 4'h0 : far_end_sync;
  end
endmodule : far_node_model
`default_nettype wire

// File: inverse_mux_pkg.sv
// constants for the inverse-mux sync, delay and out-of-frame status block
// assumes 32-bit avalon-mm words, registers in byte lane 0, byte address = index * 4
package inverse_mux_pkg;

  // number of bonded link portions
  localparam int NUM_LINKS = 4;

  // register indices
  localparam logic [7:0] IDX_COMMAND = 8'h17;
  localparam logic [7:0] IDX_SYNC_LIVE = 8'h18;
  localparam logic [7:0] IDX_SYNC_IE = 8'h19;
  localparam logic [7:0] IDX_SYNC_LATCHED = 8'h1a;
  localparam logic [7:0] IDX_DIFF_DELAY = 8'h1b;
  localparam logic [7:0] IDX_DELAY_ERR_IE = 8'h1c;
  localparam logic [7:0] IDX_DELAY_ERR_LATCHED = 8'h1d;
  localparam logic [7:0] IDX_OOF_IE = 8'h1e;
  localparam logic [7:0] IDX_OOF_LATCHED = 8'h1f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h29;

  // byte addresses on the bus
  localparam logic [7:0] ADDR_COMMAND = 8'(IDX_COMMAND * 4);
  localparam logic [7:0] ADDR_SYNC_LIVE = 8'(IDX_SYNC_LIVE * 4);
  localparam logic [7:0] ADDR_SYNC_IE = 8'(IDX_SYNC_IE * 4);
  localparam logic [7:0] ADDR_SYNC_LATCHED = 8'(IDX_SYNC_LATCHED * 4);
  localparam logic [7:0] ADDR_DIFF_DELAY = 8'(IDX_DIFF_DELAY * 4);
  localparam logic [7:0] ADDR_DELAY_ERR_IE = 8'(IDX_DELAY_ERR_IE * 4);
  localparam logic [7:0] ADDR_DELAY_ERR_LATCHED = 8'(IDX_DELAY_ERR_LATCHED * 4);
  localparam logic [7:0] ADDR_OOF_IE = 8'(IDX_OOF_IE * 4);
  localparam logic [7:0] ADDR_OOF_LATCHED = 8'(IDX_OOF_LATCHED * 4);
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'(IDX_IRQ_STATUS * 4);
  localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);

  // reset values and fixed read values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COMMAND_READ_VALUE = 8'hff;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [23:0] UPPER_LANES_ZERO = 24'h00_0000;

  // command codes
  localparam logic [7:0] CMD_LINK_START = 8'h82;

  // field positions
  localparam int DELAY_ERR_BIT = 0;
  localparam int IRQ_GLOBAL_BIT = 0;

  // differential delay scaling: 8 bits span the largest measurable delay
  localparam int DIFF_DELAY_MAX_US = 64000;
  localparam int DIFF_DELAY_LSB_US = DIFF_DELAY_MAX_US / 256;
  localparam int DIFF_DELAY_LIMIT_US = 7750;
  localparam logic [7:0] DIFF_DELAY_LIMIT_CODE = 8'(DIFF_DELAY_LIMIT_US / DIFF_DELAY_LSB_US);

endpackage : inverse_mux_pkg

// File: inverse_mux_sync_status_irq.sv
// inverse-mux sync status, latched status, differential delay and interrupt enables
// assumes status inputs come from link logic on ref_clk; bus master is avalon-mm
// Operation
// R01: each far-end sync live bit is set once a sync command for that portion has arrived.
// R02: each local sync live bit in the low nibble is set while the local receiver is in sync.
// R03: a latched copy of every live sync bit sits at the same bit position in its own register.
// R04: a far-end sync enable bit in the upper nibble lets its latched bit raise an interrupt.
// R05: a local sync enable bit in the lower nibble lets its latched bit raise an interrupt.
// R06: the measured differential delay is readable as 8 bits spanning up to 64 ms.
// R07: the delay error latched bit 0 sets when the delay exceeds 7.75 ms.
// R08: delay error enable bit 0 lets the latched delay error raise an interrupt.
// R09: out-of-frame enables hold four far-end bits high and four local bits low.
// R10: per link a far-end or local out-of-frame condition latches its own bit.
// R11: on out-of-frame, software stops transmit_allow and restarts the link handshake.
// R12: the global inverse-mux status bit sets whenever any enabled event is pending.
// R13: writing command 0x82 issues a link start so the far end hunts three sequence numbers.
// R14: latched bits set on the rising live condition and stay until software writes 1.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module inverse_mux_sync_status_irq
  import inverse_mux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NUM_LINKS-1:0] far_end_sync,
  input wire logic [NUM_LINKS-1:0] local_sync,
  input wire logic [NUM_LINKS-1:0] far_end_oof,
  input wire logic [NUM_LINKS-1:0] local_oof,
  input wire logic [7:0] diff_delay_value,
  output logic link_start,
  output logic irq
);

  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [7:0] rd_mux;
  logic req;
  logic accept;
  logic wr_hit;
  logic rd_irq_clear;
  logic [7:0] wr_byte;

  logic [7:0] sync_live_reg;
  logic [7:0] sync_prev_reg;
  logic [7:0] sync_latched_reg;
  logic [7:0] sync_ie_reg;
  logic [7:0] sync_rise;
  logic [7:0] sync_w1c;

  logic [7:0] oof_prev_reg;
  logic [7:0] oof_latched_reg;
  logic [7:0] oof_ie_reg;
  logic [7:0] oof_now;
  logic [7:0] oof_rise;
  logic [7:0] oof_w1c;

  logic [7:0] diff_delay_reg;
  logic exceed;
  logic exceed_prev_reg;
  logic delay_err_latched_reg;
  logic delay_err_ie_reg;

  logic global_pending;
  logic irq_status_reg;
  logic irq_mask_reg;
  logic irq_reg;
  logic link_start_reg;

  // bus request decode; a request is acted on at the edge where waitrequest is low
  assign req = read | write;
  assign accept = req && !waitrequest_reg;
  assign wr_byte = writedata[7:0];
  assign wr_hit = write && accept && byteenable[0];
  assign rd_irq_clear = read && accept && (address == ADDR_IRQ_STATUS);

  // one wait state, then a one-cycle answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= !(req && waitrequest_reg);
    end
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    rd_mux = REG_RESET;
    unique case (address)
      ADDR_COMMAND: rd_mux = COMMAND_READ_VALUE;
      ADDR_SYNC_LIVE: rd_mux = sync_live_reg;
      ADDR_SYNC_IE: rd_mux = sync_ie_reg;
      ADDR_SYNC_LATCHED: rd_mux = sync_latched_reg;
      ADDR_DIFF_DELAY: rd_mux = diff_delay_reg;
      ADDR_DELAY_ERR_IE: rd_mux[DELAY_ERR_BIT] = delay_err_ie_reg;
      ADDR_DELAY_ERR_LATCHED: rd_mux[DELAY_ERR_BIT] = delay_err_latched_reg;
      ADDR_OOF_IE: rd_mux = oof_ie_reg;
      ADDR_OOF_LATCHED: rd_mux = oof_latched_reg;
      ADDR_IRQ_STATUS: rd_mux[IRQ_GLOBAL_BIT] = irq_status_reg;
      ADDR_IRQ_MASK: rd_mux[IRQ_GLOBAL_BIT] = irq_mask_reg;
      default: rd_mux = REG_RESET;
    endcase
  end

  // read data captured in the wait cycle, held through the answer cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readdata_reg <= WORD_ZERO;
    end else if (read && waitrequest_reg) begin
      readdata_reg <= {UPPER_LANES_ZERO, rd_mux};
    end
  end

  // live sync status: far end in upper nibble, local in lower
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_live_reg <= REG_RESET;
      sync_prev_reg <= REG_RESET;
    end else begin
      sync_live_reg <= {far_end_sync, local_sync}; // R01 R02
      sync_prev_reg <= sync_live_reg;
    end
  end

  // write-one-to-clear masks, only on an accepted write to lane 0
  assign sync_w1c = (wr_hit && address == ADDR_SYNC_LATCHED) ? wr_byte : REG_RESET;
  assign oof_w1c = (wr_hit && address == ADDR_OOF_LATCHED) ? wr_byte : REG_RESET;
  assign sync_rise = sync_live_reg & ~sync_prev_reg;

  // latched sync copy at the live bit positions; a set beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_latched_reg <= REG_RESET;
    end else begin
      sync_latched_reg <= (sync_latched_reg & ~sync_w1c) | sync_rise; // R03 R14
    end
  end

  // out-of-frame per link: far end upper nibble, local lower nibble
  assign oof_now = {far_end_oof, local_oof};
  assign oof_rise = oof_now & ~oof_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oof_prev_reg <= REG_RESET;
      oof_latched_reg <= REG_RESET;
    end else begin
      oof_prev_reg <= oof_now;
      oof_latched_reg <= (oof_latched_reg & ~oof_w1c) | oof_rise; // R10 R14
    end
  end

  // measured differential delay, quarter-millisecond steps
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      diff_delay_reg <= REG_RESET;
    end else begin
      diff_delay_reg <= diff_delay_value; // R06
    end
  end

  // delay error latches on the rise of an over-limit measurement
  assign exceed = diff_delay_reg > DIFF_DELAY_LIMIT_CODE; // R07

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      exceed_prev_reg <= 1'b0;
      delay_err_latched_reg <= 1'b0;
    end else begin
      exceed_prev_reg <= exceed;
      if (exceed && !exceed_prev_reg) begin
        delay_err_latched_reg <= 1'b1; // R07 R14
      end else if (wr_hit && address == ADDR_DELAY_ERR_LATCHED && wr_byte[DELAY_ERR_BIT]) begin
        delay_err_latched_reg <= 1'b0;
      end
    end
  end

  // software-written enables
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_ie_reg <= REG_RESET;
      oof_ie_reg <= REG_RESET;
      delay_err_ie_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else if (wr_hit) begin
      if (address == ADDR_SYNC_IE) begin
        sync_ie_reg <= wr_byte; // R04 R05
      end
      if (address == ADDR_OOF_IE) begin
        oof_ie_reg <= wr_byte; // R09
      end
      if (address == ADDR_DELAY_ERR_IE) begin
        delay_err_ie_reg <= wr_byte[DELAY_ERR_BIT]; // R08
      end
      if (address == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wr_byte[IRQ_GLOBAL_BIT];
      end
    end
  end

  // any latched event whose enable is set
  assign global_pending = (|(sync_latched_reg & sync_ie_reg)) // R04 R05
    | (delay_err_latched_reg & delay_err_ie_reg) // R08
    | (|(oof_latched_reg & oof_ie_reg)); // R09

  // sticky global status, cleared by reading it; a new set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_status_reg <= 1'b0;
    end else if (global_pending) begin
      irq_status_reg <= 1'b1; // R12
    end else if (rd_irq_clear && readdata_reg[IRQ_GLOBAL_BIT]) begin
      irq_status_reg <= 1'b0;
    end
  end

  // level interrupt out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_status_reg & irq_mask_reg;
    end
  end

  // link start command pulse; other codes are ignored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link_start_reg <= 1'b0;
    end else begin
      link_start_reg <= wr_hit && (address == ADDR_COMMAND) && (wr_byte == CMD_LINK_START); // R13
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign link_start = link_start_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // live register follows the link inputs one cycle later
  property p_live_follows;
    ##1 1'b1 |-> sync_live_reg == $past({far_end_sync, local_sync});
  endproperty
  a_live_follows: assert property (p_live_follows) else $error("live sync wrong"); // R01 R02

  // a rising live bit is latched at its position
  property p_sync_latch_set;
    (sync_rise != REG_RESET) |=> ((sync_latched_reg & $past(sync_rise)) == $past(sync_rise));
  endproperty
  a_sync_latch_set: assert property (p_sync_latch_set) else $error("sync not latched"); // R03

  // latched sync and oof bits never drop without a write
  property p_latch_hold;
    !wr_hit |=> ((sync_latched_reg & $past(sync_latched_reg)) == $past(sync_latched_reg))
      && ((oof_latched_reg & $past(oof_latched_reg)) == $past(oof_latched_reg));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost"); // R14

  // delay value readable one cycle after the measurement
  property p_delay_value;
    ##1 1'b1 |-> diff_delay_reg == $past(diff_delay_value);
  endproperty
  a_delay_value: assert property (p_delay_value) else $error("delay value wrong"); // R06

  // an over-limit measurement latches the error two cycles on
  property p_delay_err;
    (diff_delay_value > DIFF_DELAY_LIMIT_CODE) && !exceed |-> ##2 delay_err_latched_reg;
  endproperty
  a_delay_err: assert property (p_delay_err) else $error("delay error missed"); // R07

  // an exactly-at-limit measurement does not latch the error
  property p_delay_no_err;
    !exceed && !delay_err_latched_reg && (diff_delay_value == DIFF_DELAY_LIMIT_CODE)
      && !(wr_hit) |-> ##2 !delay_err_latched_reg;
  endproperty
  a_delay_no_err: assert property (p_delay_no_err) else $error("false delay error"); // R07

  // enabled delay error reaches the interrupt pin in two cycles
  property p_delay_irq;
    delay_err_latched_reg && delay_err_ie_reg && irq_mask_reg && !wr_hit |-> ##2 irq;
  endproperty
  a_delay_irq: assert property (p_delay_irq) else $error("delay irq missing"); // R08

  // enabled sync or oof event sets global status
  property p_global;
    (|(sync_latched_reg & sync_ie_reg)) || (|(oof_latched_reg & oof_ie_reg)) |=> irq_status_reg;
  endproperty
  a_global: assert property (p_global) else $error("global status not set"); // R04 R05 R09 R12

  // an oof rise latches at its link bit
  property p_oof_latch;
    (oof_rise != REG_RESET) |=> ((oof_latched_reg & $past(oof_rise)) == $past(oof_rise));
  endproperty
  a_oof_latch: assert property (p_oof_latch) else $error("oof not latched"); // R10

  // link start is a single pulse after an accepted start write
  property p_link_start;
    wr_hit && (address == ADDR_COMMAND) && (wr_byte == CMD_LINK_START) |=> link_start ##1 !link_start;
  endproperty
  a_link_start: assert property (p_link_start) else $error("link start pulse wrong"); // R13

  // every request is answered the next cycle
  property p_answer;
    req && waitrequest_reg |=> !waitrequest_reg;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  // waitrequest is low for a single cycle per request
  property p_one_wait;
    !waitrequest_reg |=> waitrequest_reg;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer too long");

  // the pin follows status and mask one cycle later
  property p_irq_level;
    ##1 1'b1 |-> irq == $past(irq_status_reg && irq_mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // R12

  // a status read with nothing pending clears the global bit
  property p_status_clear;
    rd_irq_clear && readdata_reg[IRQ_GLOBAL_BIT] && !global_pending |=> !irq_status_reg;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // R12

  // an accepted sync enable write lands in full
  property p_sync_ie_write;
    wr_hit && (address == ADDR_SYNC_IE) |=> sync_ie_reg == $past(wr_byte);
  endproperty
  a_sync_ie_write: assert property (p_sync_ie_write) else $error("sync enable lost"); // R04 R05

endmodule : inverse_mux_sync_status_irq

`default_nettype wire

// File: tb.sv
// testbench for the inverse-mux status and interrupt block
// assumes the far node model drives the sync inputs; bench drives bus, delay and oof
`timescale 1ns/100ps
`default_nettype none
module tb;
  import inverse_mux_pkg::*;
  logic ref_clk, srst, read, write, waitrequest, link_start, irq;
  logic [7:0] address, diff_delay_value, rdat;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, far_end_sync, local_sync, far_end_oof, local_oof, portion_en;
  logic [7:0] ie_tab[5], lat_tab[5], val_tab[5];
  int err_count, n_checks;
  int n_starts = 0;

  inverse_mux_sync_status_irq i_dut (.ref_clk(ref_clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .far_end_sync(far_end_sync),
    .local_sync(local_sync), .far_end_oof(far_end_oof), .local_oof(local_oof),
    .diff_delay_value(diff_delay_value), .link_start(link_start), .irq(irq));
  far_node_model i_far (.ref_clk(ref_clk), .srst(srst), .link_start(link_start),
    .portion_en(portion_en), .far_end_sync(far_end_sync), .local_sync(local_sync));

  // free-running 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // counts link start pulses on the device output, one per high cycle
  always @(posedge ref_clk) begin
    if (link_start === 1'b1) begin
      n_starts <= n_starts + 1;
    end
  end

  // compare one value, count and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // wait for the answer edge of the request already raised
  task automatic wait_ans();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
  endtask : wait_ans

  // avalon write, request held until waitrequest is seen low
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= 1'b1;
    wait_ans();
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // avalon read, data taken at the answer edge
  task automatic rd(input logic [7:0] a);
    address <= a;
    read <= 1'b1;
    wait_ans();
    rdat = readdata[7:0];
    read <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // cuts a hang short
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    diff_delay_value = 8'h00;
    far_end_oof = 4'h0;
    local_oof = 4'h0;
    portion_en = 4'h0;
    err_count = 0;
    n_checks = 0;
    ie_tab = '{ADDR_SYNC_IE, ADDR_SYNC_IE, ADDR_DELAY_ERR_IE, ADDR_OOF_IE, ADDR_OOF_IE};
    lat_tab = '{ADDR_SYNC_LATCHED, ADDR_SYNC_LATCHED, ADDR_DELAY_ERR_LATCHED,
      ADDR_OOF_LATCHED, ADDR_OOF_LATCHED};
    val_tab = '{8'hf0, 8'h0f, 8'h01, 8'hf0, 8'h0f};
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // reset values of the eight sync, delay and oof registers and the command read value
    for (int i = 0; i < 8; i++) begin
      rd(8'(ADDR_SYNC_LIVE + 8'(4 * i)));
      chk(rdat, REG_RESET);
    end
    rd(ADDR_COMMAND);
    chk(rdat, COMMAND_READ_VALUE);
    $display("test reset values done");
    // enables read back, refused writes leave state alone
    wr(ADDR_SYNC_IE, 8'ha5);
    wr(ADDR_OOF_IE, 8'h5a);
    wr(ADDR_DELAY_ERR_IE, 8'hff);
    byteenable <= 4'h0;
    wr(ADDR_SYNC_IE, 8'h00);
    byteenable <= 4'hf;
    rd(ADDR_SYNC_IE);
    chk(rdat, 8'ha5);
    rd(ADDR_OOF_IE);
    chk(rdat, 8'h5a);
    rd(ADDR_DELAY_ERR_IE);
    chk(rdat, 8'h01);
    wr(8'hfc, 8'hff);
    rd(8'hfc);
    chk(rdat, REG_RESET);
    wr(ADDR_SYNC_LIVE, 8'hff);
    rd(ADDR_SYNC_LIVE);
    chk(rdat, REG_RESET);
    for (int i = 0; i < 5; i++) begin
      wr(ie_tab[i], 8'h00);
    end
    $display("test enables done");
    // link start brings portions 1 and 4 into sync
    portion_en <= 4'h9;
    wr(ADDR_COMMAND, CMD_LINK_START);
    repeat (12) @(posedge ref_clk);
    chk(8'(n_starts), 8'h01);
    rd(ADDR_SYNC_LIVE);
    chk(rdat, 8'h99);
    rd(ADDR_SYNC_LATCHED);
    chk(rdat, 8'h99);
    $display("test link start done");
    // differential delay at and above the error limit
    diff_delay_value <= DIFF_DELAY_LIMIT_CODE;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_DIFF_DELAY);
    chk(rdat, 8'h1f);
    rd(ADDR_DELAY_ERR_LATCHED);
    chk(rdat, 8'h00);
    diff_delay_value <= DIFF_DELAY_LIMIT_CODE + 8'h01;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_DIFF_DELAY);
    chk(rdat, 8'h20);
    rd(ADDR_DELAY_ERR_LATCHED);
    chk(rdat, 8'h01);
    // out-of-frame on far-end links 1,3 and local links 2,4
    far_end_oof <= 4'h5;
    local_oof <= 4'ha;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_OOF_LATCHED);
    chk(rdat, 8'h5a);
    $display("test delay and oof done");
    // nothing enabled: no global status, no irq
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_IRQ_STATUS);
    chk(rdat, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // each enable group raises irq until its latched bits are cleared
    for (int i = 0; i < 5; i++) begin
      wr(ie_tab[i], val_tab[i]);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_IRQ_STATUS);
      chk(rdat, 8'h01);
      if (i == 0) begin
        wr(ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk({7'h00, irq}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
      end
      wr(lat_tab[i], val_tab[i]);
      wr(ie_tab[i], 8'h00);
      rd(ADDR_IRQ_STATUS);
      rd(ADDR_IRQ_STATUS);
      chk(rdat, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk({7'h00, irq}, 8'h00);
    end
    $display("test interrupts done");
    // out-of-frame recovery: a nop is ignored, a fresh link start re-syncs
    wr(ADDR_COMMAND, 8'hff);
    wr(ADDR_COMMAND, CMD_LINK_START);
    repeat (12) @(posedge ref_clk);
    chk(8'(n_starts), 8'h02);
    rd(ADDR_SYNC_LATCHED);
    chk(rdat, 8'h99);
    $display("test link restart done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
